// ---- src/power_state_sequencer.sv ----
// Operating-state sequencer with radio hold-off for a mesh manager module.
`timescale 1ns/1ps
`default_nettype none
module power_state_sequencer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control pins from the host
  input wire logic reset_pin_low,
  input wire logic flash_program_select_n,
  input wire logic radio_hold_off,
  // Fuse table source
  input wire logic [15:0] fuse_data,
  output logic [3:0] fuse_addr,
  // Demand and radio requests
  input wire power_seq_pkg::demand_s demand,
  input wire power_seq_pkg::radio_req_s radio,
  input wire logic ext_sram_present,
  // Outputs
  output power_seq_pkg::pwr_state_e state,
  output power_seq_pkg::power_ctl_s power_ctl,
  output power_seq_pkg::capacity_s capacity,
  output logic [15:0] io_dir,
  output logic radio_grant,
  output logic radio_enable,
  output logic flash_emu_active,
  output logic fuse_loaded
);
  import power_seq_pkg::*;

  // ****************************************
  // Pin synchronizers
  // ****************************************
  logic reset_pin_low_s;
  logic hold_off_s;

  sync2 u_sync_reset (
    .core_clk(core_clk),
    .rst(rst),
    .rst_val(1'b0),
    .async_in(reset_pin_low),
    .sync_out(reset_pin_low_s)
  );

  // Hold-off starts out as held, so that no radio start can slip through before the pin is first seen.
  // Hold-off sync.
  sync2 u_sync_hold (
    .core_clk(core_clk),
    .rst(rst),
    .rst_val(1'b1),
    .async_in(radio_hold_off),
    .sync_out(hold_off_s)
  );

  // ****************************************
  // State record
  // ****************************************
  typedef struct packed {
    pwr_state_e st;
    logic [3:0] fuse_idx;
    logic [15:0] io_dir;
    logic fuse_done;
    logic [7:0] boot_cnt;
    logic rst_pin_prev;
    logic radio_on;
    logic radio_grant;
    logic [9:0] lf_cnt;
    logic lf_tick;
    power_ctl_s ctl;
    capacity_s cap;
  } seq_s;

  seq_s cur_q;
  seq_s nxt_d;

  function automatic logic all_idle(input demand_s d);
    all_idle = !d.cpu_busy && !d.periph_busy && (d.periph_req == 16'h0000);
  endfunction

  always_comb begin
    nxt_d = cur_q;
    nxt_d.rst_pin_prev = reset_pin_low_s;
    nxt_d.lf_tick = 1'b0;
    if (cur_q.lf_cnt == LF_DIV_LAST) begin
      nxt_d.lf_cnt = 10'h000;
      nxt_d.lf_tick = 1'b1;
    end else begin
      nxt_d.lf_cnt = cur_q.lf_cnt + 10'h001;
    end
    nxt_d.cap.max_motes = ext_sram_present ? MOTES_SRAM : MOTES_NO_SRAM;
    nxt_d.cap.max_pps = ext_sram_present ? PPS_SRAM : PPS_NO_SRAM;
    // A reload wins over every state, so a pulse on the reset pin that is sampled at a clock edge always restarts the table.
    // Reload fuses on reset edge.
    if (reset_pin_low_s && !cur_q.rst_pin_prev) begin
      nxt_d.st = ST_FUSE;
      nxt_d.fuse_idx = 4'h0;
      nxt_d.fuse_done = 1'b0;
    end else begin
      case (cur_q.st)
        ST_FUSE: begin
          if (cur_q.fuse_idx == 4'h0) begin
            nxt_d.io_dir = fuse_data;
          end
          if (cur_q.fuse_idx == FUSE_LAST) begin
            nxt_d.fuse_done = 1'b1;
            if (reset_pin_low_s && !flash_program_select_n) begin
              nxt_d.st = ST_FLASH_EMU;
            end else if (reset_pin_low_s) begin
              nxt_d.st = ST_MIN_ENERGY;
            end else begin
              nxt_d.st = ST_BOOT;
              nxt_d.boot_cnt = BOOT_COUNT;
            end
          end else begin
            nxt_d.fuse_idx = cur_q.fuse_idx + 4'h1;
          end
        end
        ST_MIN_ENERGY, ST_FLASH_EMU: begin
          if (!reset_pin_low_s) begin
            nxt_d.st = ST_BOOT;
            nxt_d.boot_cnt = BOOT_COUNT;
          end
        end
        ST_BOOT: begin
          if (cur_q.boot_cnt == 8'h00) begin
            nxt_d.st = ST_CPU_ACTIVE;
          end else begin
            nxt_d.boot_cnt = cur_q.boot_cnt - 8'h01;
          end
        end
        ST_CPU_ACTIVE, ST_CPU_IDLE: begin
          // Lowest state meeting demand; doze only when all idle.
          if (demand.cpu_busy) begin
            nxt_d.st = ST_CPU_ACTIVE;
          end else if (all_idle(demand) && !cur_q.radio_on) begin
            nxt_d.st = ST_DOZE;
          end else begin
            nxt_d.st = ST_CPU_IDLE;
          end
        end
        ST_DOZE: begin
          if (demand.uart_activity || !demand.time_strobe_n || !all_idle(demand)) begin
            nxt_d.st = demand.cpu_busy ? ST_CPU_ACTIVE : ST_CPU_IDLE;
          end
        end
        default: begin
          nxt_d.st = ST_FUSE;
        end
      endcase
    end
    // In the run states the grant is raised each cycle a request waits with no hold-off and no op busy, while the enable covers the whole operation.
    // Hold-off therefore only blocks grants and never cuts an enable that is still busy.
    // No new radio start under hold-off; running op finishes.
    nxt_d.radio_grant = 1'b0;
    if (cur_q.st == ST_CPU_ACTIVE || cur_q.st == ST_CPU_IDLE) begin
      if (radio.radio_req && !hold_off_s && !radio.radio_op_busy) begin
        nxt_d.radio_grant = 1'b1;
        nxt_d.radio_on = 1'b1;
      end else if (!radio.radio_op_busy && (hold_off_s || !radio.radio_req)) begin
        nxt_d.radio_on = 1'b0;
      end
    end else begin
      nxt_d.radio_on = 1'b0;
    end
    // Oscillator and peripheral enables; low-frequency always on.
    nxt_d.ctl.lf_osc_en = 1'b1;
    nxt_d.ctl.lf_tick = nxt_d.lf_tick;
    nxt_d.ctl.relax_osc_en = (nxt_d.st != ST_DOZE) && (nxt_d.st != ST_MIN_ENERGY);
    nxt_d.ctl.cpu_run = (nxt_d.st == ST_CPU_ACTIVE) || (nxt_d.st == ST_BOOT);
    nxt_d.ctl.periph_en = (nxt_d.st == ST_CPU_ACTIVE || nxt_d.st == ST_CPU_IDLE) ? demand.periph_req : 16'h0000;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur_q <= '{st: ST_FUSE, fuse_idx: 4'h0, io_dir: IO_DIR_RESET, fuse_done: 1'b0, boot_cnt: 8'h00,
                 rst_pin_prev: 1'b0, radio_on: 1'b0, radio_grant: 1'b0, lf_cnt: 10'h000, lf_tick: 1'b0,
                 ctl: '0, cap: '0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign state = cur_q.st;
  assign power_ctl = cur_q.ctl;
  assign capacity = cur_q.cap;
  assign io_dir = cur_q.io_dir;
  assign fuse_addr = cur_q.fuse_idx;
  assign radio_grant = cur_q.radio_grant;
  assign radio_enable = cur_q.radio_on;
  assign flash_emu_active = (cur_q.st == ST_FLASH_EMU);
  assign fuse_loaded = cur_q.fuse_done;
endmodule
`default_nettype wire

// ---- src/power_seq_pkg.sv ----
// Package with constants, states and carriers for the power state sequencer.
`default_nettype none
package power_seq_pkg;

  // ****************************************
  // Timing and capacity constants
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned FUSE_WORDS = 8;
  localparam logic [3:0] FUSE_LAST = 4'h7;
  localparam int unsigned BOOT_NS = 2_000;
  localparam int unsigned BOOT_CYCLES = (BOOT_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam logic [7:0] BOOT_COUNT = 8'(BOOT_CYCLES);
  localparam int unsigned LF_HZ = 32_768;
  localparam int unsigned LF_DIV = CLK_HZ / (2 * LF_HZ);
  localparam logic [9:0] LF_DIV_LAST = 10'(LF_DIV - 1);
  localparam logic [7:0] MOTES_NO_SRAM = 8'h20;
  localparam logic [7:0] MOTES_SRAM = 8'h64;
  localparam logic [7:0] PPS_NO_SRAM = 8'h18;
  localparam logic [7:0] PPS_SRAM = 8'h24;
  localparam logic [15:0] IO_DIR_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_FUSE = 3'b000,
    ST_MIN_ENERGY = 3'b001,
    ST_FLASH_EMU = 3'b010,
    ST_BOOT = 3'b011,
    ST_CPU_ACTIVE = 3'b100,
    ST_CPU_IDLE = 3'b101,
    ST_DOZE = 3'b110
  } pwr_state_e;

  typedef struct packed {
    logic cpu_busy;
    logic periph_busy;
    logic [15:0] periph_req;
    logic uart_activity;
    logic time_strobe_n;
  } demand_s;

  typedef struct packed {
    logic radio_req;
    logic radio_op_busy;
  } radio_req_s;

  typedef struct packed {
    logic relax_osc_en;
    logic lf_osc_en;
    logic lf_tick;
    logic [15:0] periph_en;
    logic cpu_run;
  } power_ctl_s;

  typedef struct packed {
    logic [7:0] max_motes;
    logic [7:0] max_pps;
  } capacity_s;

endpackage
`default_nettype wire

// ---- src/sync2.sv ----
// Two-stage level synchronizer.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rst_val,
  // Data
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= rst_val;
      sync_q <= rst_val;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ---- bench/power_seq_monitor.sv ----
// Port checker for the power state sequencer.
`timescale 1ns/1ps
`default_nettype none
module power_seq_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Inputs
  input wire logic reset_pin_low,
  input wire logic flash_program_select_n,
  input wire logic radio_hold_off,
  input wire power_seq_pkg::demand_s demand,
  input wire power_seq_pkg::radio_req_s radio,
  input wire logic ext_sram_present,
  // Outputs
  input wire logic [3:0] fuse_addr,
  input wire power_seq_pkg::pwr_state_e state,
  input wire power_seq_pkg::capacity_s capacity,
  input wire logic radio_grant,
  input wire logic radio_enable
);
  import power_seq_pkg::*;
  // Boot stands one cycle longer than its count.
  localparam int BOOT_LEN = BOOT_CYCLES + 1;
  logic busy;
  assign busy = demand.cpu_busy | demand.periph_busy | (|demand.periph_req) | radio_enable;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ********
  // Assertions
  // ********
  a_hold_grant: assert property (
    radio_hold_off [*3] |=> !radio_grant) else $error("grant under hold-off");
  a_grant_place: assert property (
    radio_grant |-> $past(state) inside {ST_CPU_ACTIVE, ST_CPU_IDLE}) else $error("grant outside run");
  a_op_kept: assert property (
    radio_enable && radio.radio_op_busy && !reset_pin_low |=> radio_enable) else $error("op cut short");
  a_flash_entry: assert property (
    reset_pin_low [*5] ##0 (state == ST_FUSE && fuse_addr == FUSE_LAST && !flash_program_select_n)
    |=> state == ST_FLASH_EMU) else $error("no flash emulation");
  a_min_hold: assert property (
    reset_pin_low [*4] ##0 state == ST_MIN_ENERGY |=> state == ST_MIN_ENERGY) else $error("left min energy");
  a_boot_len: assert property (
    $rose(state == ST_BOOT) |-> ##BOOT_LEN state == ST_CPU_ACTIVE) else $error("boot length");
  a_doze_idle: assert property (
    state == ST_DOZE && $past(state) != ST_DOZE |-> !$past(busy)) else $error("doze while busy");
  a_doze_wake: assert property (
    state == ST_DOZE && (demand.uart_activity || !demand.time_strobe_n) |=> state != ST_DOZE)
    else $error("no wake");
  a_cap_table: assert property (
    !$past(rst) |-> capacity == ($past(ext_sram_present) ? {MOTES_SRAM, PPS_SRAM} : {MOTES_NO_SRAM, PPS_NO_SRAM}))
    else $error("capacity");
endmodule
bind power_state_sequencer power_seq_monitor mon (.core_clk, .rst, .reset_pin_low, .flash_program_select_n,
  .radio_hold_off, .demand, .radio, .ext_sram_present, .fuse_addr, .state, .capacity, .radio_grant, .radio_enable);
`default_nettype wire

// ---- bench/host_ctrl_model.sv ----
// Host model driving the control pins and serving the fuse table.
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model #(
  parameter logic [15:0] DIR_WORD = 16'hC3A5
) (
  // Commands: reset, flash select, hold-off
  input wire logic [2:0] cmd,
  // Pins
  output logic reset_pin_low,
  output logic flash_program_select_n,
  output logic radio_hold_off,
  // Fuse table
  input wire logic [3:0] fuse_addr,
  output logic [15:0] fuse_data
);
  assign reset_pin_low = cmd[0];
  assign flash_program_select_n = ~cmd[1];
  assign radio_hold_off = cmd[2];
  // Other rows differ from row 0, so a wrong row cannot pass.
  assign fuse_data = (fuse_addr == 4'h0) ? DIR_WORD : {4{fuse_addr}};
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the power state sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import power_seq_pkg::*;
  localparam logic [15:0] DIR_WORD = 16'hC3A5;
  localparam demand_s IDLE = 20'h0_0001;
  localparam demand_s BUSY = 20'h8_0001;
  logic core_clk, rst, ext_sram_present, reset_pin_low, flash_program_select_n, radio_hold_off;
  logic radio_grant, radio_enable, flash_emu_active, fuse_loaded;
  logic [2:0] cmd;
  logic [3:0] fuse_addr;
  logic [15:0] fuse_data, io_dir;
  demand_s demand;
  radio_req_s radio;
  pwr_state_e state;
  power_ctl_s power_ctl;
  capacity_s capacity;
  int bad_count, cmp_count;
  power_state_sequencer DUT (.core_clk, .rst, .reset_pin_low, .flash_program_select_n, .radio_hold_off,
    .fuse_data, .fuse_addr, .demand, .radio, .ext_sram_present, .state, .power_ctl, .capacity, .io_dir,
    .radio_grant, .radio_enable, .flash_emu_active, .fuse_loaded);
  host_ctrl_model #(.DIR_WORD(DIR_WORD)) host (.cmd, .reset_pin_low, .flash_program_select_n,
    .radio_hold_off, .fuse_addr, .fuse_data);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ********
  // Helpers
  // ********
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Bounded wait, so a stuck state shows as a mismatch rather than a hang.
  task automatic wait_st(input pwr_state_e s, input int lim);
    int n;
    n = 0;
    while (state !== s && n < lim) begin
      cyc(1);
      n++;
    end
    check(16'(state), 16'(s));
  endtask
  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_boot();
    int n;
    n = 0;
    wait_st(ST_BOOT, 12);
    while (state === ST_BOOT && n < 60) begin
      cyc(1);
      n++;
    end
    check(16'(n), 16'(BOOT_COUNT) + 16'h0001);
    check(16'(state), 16'(ST_CPU_ACTIVE));
    check(io_dir, DIR_WORD);
    check(16'(fuse_loaded), 16'h0001);
  endtask
  task automatic t_cap();
    cyc(2);
    check(capacity, {MOTES_NO_SRAM, PPS_NO_SRAM});
    ext_sram_present = 1'b1;
    cyc(2);
    check(capacity, {MOTES_SRAM, PPS_SRAM});
  endtask
  task automatic t_doze();
    int n;
    n = 0;
    demand.periph_req = 16'h0005;
    cyc(3);
    check(power_ctl.periph_en, 16'h0005);
    check(16'(power_ctl.relax_osc_en), 16'h0001);
    check(16'(power_ctl.cpu_run), 16'h0001);
    demand = IDLE;
    wait_st(ST_DOZE, 4);
    check(16'(power_ctl.lf_osc_en), 16'h0001);
    check(16'(power_ctl.relax_osc_en), 16'h0000);
    check(power_ctl.periph_en, 16'h0000);
    // The slow timebase must keep its period while the main oscillator is parked.
    while (power_ctl.lf_tick !== 1'b1 && n < 2 * LF_DIV) begin
      cyc(1);
      n++;
    end
    n = 0;
    cyc(1);
    while (power_ctl.lf_tick !== 1'b1 && n < 2 * LF_DIV) begin
      cyc(1);
      n++;
    end
    check(16'(n + 1), 16'(LF_DIV));
    check(16'(state), 16'(ST_DOZE));
    check(io_dir, DIR_WORD);
    demand.uart_activity = 1'b1;
    cyc(1);
    check(16'(state != ST_DOZE), 16'h0001);
    demand = IDLE;
    wait_st(ST_DOZE, 4);
    demand.time_strobe_n = 1'b0;
    cyc(1);
    check(16'(state != ST_DOZE), 16'h0001);
    demand = BUSY;
    wait_st(ST_CPU_ACTIVE, 3);
  endtask
  task automatic t_radio();
    int hits;
    hits = 0;
    cmd = 3'b100;
    cyc(4);
    radio.radio_req = 1'b1;
    repeat (6) begin
      cyc(1);
      if (radio_grant !== 1'b0) hits++;
    end
    check(16'(hits), 16'h0000);
    cmd = 3'b000;
    while (radio_grant !== 1'b1 && hits < 8) begin
      cyc(1);
      hits++;
    end
    check(16'(radio_grant), 16'h0001);
    radio = 2'b01;
    cmd = 3'b100;
    cyc(6);
    check(16'(radio_enable), 16'h0001);
    radio = 2'b00;
    cyc(3);
    check(16'(radio_enable), 16'h0000);
    cmd = 3'b000;
    cyc(1);
  endtask
  task automatic t_pins();
    cmd = 3'b011;
    wait_st(ST_FUSE, 6);
    check(16'(fuse_addr), 16'h0000);
    check(16'(fuse_loaded), 16'h0000);
    wait_st(ST_FLASH_EMU, 12);
    check(16'(flash_emu_active), 16'h0001);
    check(16'(power_ctl.cpu_run), 16'h0000);
    check(io_dir, DIR_WORD);
    cmd = 3'b000;
    wait_st(ST_CPU_ACTIVE, 60);
    cmd = 3'b001;
    wait_st(ST_MIN_ENERGY, 16);
    cyc(20);
    check(16'(state), 16'(ST_MIN_ENERGY));
    check(16'(power_ctl.relax_osc_en), 16'h0000);
    cmd = 3'b000;
    wait_st(ST_CPU_ACTIVE, 60);
  endtask
  initial begin
    rst = 1'b1;
    cmd = 3'b000;
    ext_sram_present = 1'b0;
    demand = BUSY;
    radio = 2'b00;
    bad_count = 0;
    cmp_count = 0;
    cyc(2);
    rst = 1'b0;
    t_boot();
    t_cap();
    t_doze();
    t_radio();
    t_pins();
    end_sim();
  end
  initial begin
    // The scenarios need about 800 cycles, most of them waiting for the first two slow ticks.
    #200_000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
